// *** verilog/sc_timing_pkg.sv ***
// Constants, field layouts and types of the smart-card timing block.
//
// Summary of operation
// - Guard time is eleven ETU plus setting.
// - Four-bit limit on parity-error character repetitions.
// - Eight-bit reverse delay, value equals delay units.
// - Bits 15:8 divide clock for interface chip.
// - Bits 7:0 divide clock for the card.
// - Transmissions performed equal transmit count plus one.
// - Auto switch to receive when enable bit 13.
// - Interrupt when parity errors reach threshold plus one.
// - Interrupt when receptions reach threshold plus one.
// - Write-only bit 8 enables automatic parity.
// - First reset-answer byte compared; mismatch changes parity.
// - Automatic parity off: parity is fixed setting.
// - One ETU is ten tuning plus fine.
package sc_timing_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_BAUD = 8'h10;
    localparam logic [7:0] OFF_GUARD_TIME = 8'h1C;
    localparam logic [7:0] OFF_REPEAT_LIMIT = 8'h20;
    localparam logic [7:0] OFF_REVERSE_DELAY = 8'h24;
    localparam logic [7:0] OFF_CLOCK_DIVIDER = 8'h28;
    localparam logic [7:0] OFF_TRANSMIT_COUNT = 8'h2C;
    localparam logic [7:0] OFF_PE_THRESHOLD = 8'h30;
    localparam logic [7:0] OFF_RX_THRESHOLD = 8'h34;
    localparam logic [7:0] OFF_AUTO_PARITY = 8'h38;
    localparam logic [7:0] OFF_INT_STATUS = 8'h44;
    localparam logic [7:0] OFF_INT_ENABLE = 8'h48;

    // ****************************************************************
    // Fields and reset values
    // ****************************************************************
    localparam int CTRL_DIR_RX = 0;
    localparam int CTRL_FIXED_PAR = 5;
    localparam int BAUD_FINE_LSB = 0;
    localparam int BAUD_TUNING_LSB = 4;
    localparam int DIV_CARD_LSB = 0;
    localparam int DIV_IF_LSB = 8;
    localparam int AUTO_ON_BIT = 8;
    localparam int STAT_PE_REACHED = 2;
    localparam int STAT_REP_EXCEEDED = 6;
    localparam int STAT_TX_DONE = 13;
    localparam int STAT_RX_REACHED = 14;
    localparam int IER_AUTO_SWITCH = 13;
    localparam logic [15:0] STATUS_USED = 16'h6044;
    localparam logic RST_DIR_RX = 1'b1;
    localparam logic [8:0] GUARD_BASE_ETU = 9'h00B;
    localparam logic [3:0] ETU_MULT = 4'hA;
    localparam logic [13:0] ETU_MIN = 14'h0001;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef struct packed {
        logic [1:0] htrans;
        logic [31:0] haddr;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hsel;
        logic hready;
    } ahb_req_t;

    typedef struct packed {
        logic tx_char_done;
        logic rx_char_done;
        logic rx_parity_err;
        logic first_reset_answer_byte_valid;
        logic [7:0] rx_byte;
        logic guard_start;
    } line_evt_t;

    typedef struct packed {
        logic [7:0] guard_time;
        logic [3:0] parity_repeat_max;
        logic [7:0] rev_delay;
        logic [7:0] interface_clock_divider;
        logic [7:0] card_div;
        logic [15:0] tx_num;
        logic [15:0] pe_num;
        logic [15:0] rx_num;
        logic auto_parity_on;
        logic [7:0] first_byte_match_value;
        logic dir_rx;
        logic fixed_parity_select;
        logic [9:0] tuning;
        logic [3:0] fine;
        logic [15:0] status;
        logic [15:0] interrupt_enable_reg;
        logic [15:0] tx_cnt;
        logic [15:0] pe_cnt;
        logic [15:0] rx_cnt;
        logic [3:0] rep_cnt;
        logic [7:0] card_pre;
        logic [7:0] if_pre;
        logic card_clk;
        logic if_clk;
        logic [13:0] etu_cnt;
        logic etu_tick;
        logic [8:0] guard_cnt;
        logic guard_busy;
        logic par_flip;
        logic par_out;
        logic irq;
        logic wr_pend;
        logic rd_pend;
        logic [7:0] addr;
        logic [31:0] hrdata;
        logic hready;
    } state_t;

endpackage

// *** verilog/sc_timing.sv ***
// Smart-card character timing, counters and parity selection block.
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/10ps
module sc_timing
    import sc_timing_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Character events from the serial engine
    input wire logic tx_char_done,
    input wire logic rx_char_done,
    input wire logic rx_parity_err,
    input wire logic first_reset_answer_byte_valid,
    input wire logic [7:0] rx_byte,
    input wire logic guard_start,
    // Timing and control outputs
    output logic card_clk,
    output logic interface_clk,
    output logic etu_tick,
    output logic guard_busy,
    output logic rx_direction,
    output logic parity_select,
    output logic [3:0] repeat_limit,
    output logic [7:0] reverse_delay,
    output logic irq
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [13:0] etu_len(input logic [9:0] t,
                                            input logic [3:0] f);
        logic [13:0] v;
        v = 14'(t) * 14'(ETU_MULT);
        v = v + 14'(f);
        if (v == '0) begin
            v = ETU_MIN;
        end
        return v;
    endfunction

    function automatic logic [15:0] step(input logic [15:0] c,
                                         input logic [15:0] lim);
        return (c == lim) ? 16'h0000 : c + 16'h0001;
    endfunction

    state_t st;
    state_t nx;
    line_evt_t ev;
    logic accept;
    logic wr_now;
    logic card_tick;
    logic card_rise;
    logic [15:0] w1c;
    logic [15:0] set_bits;
    logic [31:0] rd_mux;

    assign ev = '{tx_char_done, rx_char_done, rx_parity_err,
                  first_reset_answer_byte_valid, rx_byte, guard_start};
    assign accept = hsel && htrans[1] && hready;
    assign wr_now = st.wr_pend;
    assign card_tick = (st.card_pre == st.card_div);
    assign card_rise = card_tick && !st.card_clk;

    // ****************************************************************
    // Read multiplexer
    // ****************************************************************
    always_comb begin
        rd_mux = '0;
        unique case (st.addr)
            OFF_CONTROL: begin
                rd_mux[CTRL_DIR_RX] = st.dir_rx;
                rd_mux[CTRL_FIXED_PAR] = st.fixed_parity_select;
            end
            OFF_BAUD: begin
                rd_mux[BAUD_TUNING_LSB +: 10] = st.tuning;
                rd_mux[BAUD_FINE_LSB +: 4] = st.fine;
            end
            OFF_GUARD_TIME: rd_mux[7:0] = st.guard_time;
            OFF_REPEAT_LIMIT: rd_mux[3:0] = st.parity_repeat_max;
            OFF_REVERSE_DELAY: rd_mux[7:0] = st.rev_delay;
            OFF_CLOCK_DIVIDER: begin
                rd_mux[DIV_IF_LSB +: 8] = st.interface_clock_divider;
                rd_mux[DIV_CARD_LSB +: 8] = st.card_div;
            end
            OFF_TRANSMIT_COUNT: rd_mux[15:0] = st.tx_num;
            OFF_PE_THRESHOLD: rd_mux[15:0] = st.pe_num;
            OFF_RX_THRESHOLD: rd_mux[15:0] = st.rx_num;
            OFF_INT_STATUS: rd_mux[15:0] = st.status;
            OFF_INT_ENABLE: rd_mux[15:0] = st.interrupt_enable_reg;
            default: rd_mux = '0;
        endcase
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        nx = st;
        set_bits = '0;
        w1c = '0;
        // Bus: writes complete with no wait, reads take one wait state.
        nx.wr_pend = accept && hwrite;
        nx.rd_pend = accept && !hwrite;
        if (accept) begin
            nx.addr = haddr[ADDR_W-1:0];
        end
        nx.hready = !(accept && !hwrite);
        if (st.rd_pend) begin
            nx.hrdata = rd_mux;
        end
        if (wr_now) begin
            unique case (st.addr)
                OFF_CONTROL: begin
                    nx.dir_rx = hwdata[CTRL_DIR_RX];
                    nx.fixed_parity_select = hwdata[CTRL_FIXED_PAR];
                end
                OFF_BAUD: begin
                    nx.tuning = hwdata[BAUD_TUNING_LSB +: 10];
                    nx.fine = hwdata[BAUD_FINE_LSB +: 4];
                end
                OFF_GUARD_TIME: nx.guard_time = hwdata[7:0];
                OFF_REPEAT_LIMIT: nx.parity_repeat_max = hwdata[3:0];
                OFF_REVERSE_DELAY: nx.rev_delay = hwdata[7:0];
                OFF_CLOCK_DIVIDER: begin
                    nx.interface_clock_divider = hwdata[DIV_IF_LSB +: 8];
                    nx.card_div = hwdata[DIV_CARD_LSB +: 8];
                end
                OFF_TRANSMIT_COUNT: nx.tx_num = hwdata[15:0];
                OFF_PE_THRESHOLD: nx.pe_num = hwdata[15:0];
                OFF_RX_THRESHOLD: nx.rx_num = hwdata[15:0];
                OFF_AUTO_PARITY: begin
                    nx.auto_parity_on = hwdata[AUTO_ON_BIT];
                    nx.first_byte_match_value = hwdata[7:0];
                end
                OFF_INT_STATUS: w1c = hwdata[15:0];
                OFF_INT_ENABLE: nx.interrupt_enable_reg = hwdata[15:0];
                default: nx.addr = st.addr;
            endcase
        end
        // Clock dividers: each output toggles once per divided period.
        nx.card_pre = card_tick ? 8'h00 : st.card_pre + 8'h01;
        nx.card_clk = card_tick ? !st.card_clk : st.card_clk;
        if (st.if_pre == st.interface_clock_divider) begin
            nx.if_pre = 8'h00;
            nx.if_clk = !st.if_clk;
        end else begin
            nx.if_pre = st.if_pre + 8'h01;
        end
        // ETU counted in rising edges of the card clock.
        nx.etu_tick = 1'b0;
        if (card_rise) begin
            if (st.etu_cnt >= etu_len(st.tuning, st.fine) - ETU_MIN) begin
                nx.etu_cnt = '0;
                nx.etu_tick = 1'b1;
            end else begin
                nx.etu_cnt = st.etu_cnt + ETU_MIN;
            end
        end
        // Guard time: a restart while busy is ignored.
        if (ev.guard_start && !st.guard_busy) begin
            nx.guard_cnt = GUARD_BASE_ETU + {1'b0, st.guard_time};
        end else if (st.etu_tick && st.guard_cnt != '0) begin
            nx.guard_cnt = st.guard_cnt - 9'h001;
        end
        nx.guard_busy = (nx.guard_cnt != '0);
        // Transmit count and automatic switch to receive.
        if (ev.tx_char_done && !st.dir_rx) begin
            nx.tx_cnt = step(st.tx_cnt, st.tx_num);
            if (st.tx_cnt == st.tx_num) begin
                set_bits[STAT_TX_DONE] = 1'b1;
                if (st.interrupt_enable_reg[IER_AUTO_SWITCH]) begin
                    nx.dir_rx = 1'b1;
                end
            end
        end
        if (nx.dir_rx) begin
            nx.tx_cnt = '0;
        end
        // Parity errors: threshold count and repetition limit.
        if (ev.rx_parity_err) begin
            nx.pe_cnt = step(st.pe_cnt, st.pe_num);
            set_bits[STAT_PE_REACHED] = (st.pe_cnt == st.pe_num);
            if (st.rep_cnt == st.parity_repeat_max) begin
                set_bits[STAT_REP_EXCEEDED] = 1'b1;
                nx.rep_cnt = '0;
            end else begin
                nx.rep_cnt = st.rep_cnt + 4'h1;
            end
        end else if (ev.rx_char_done) begin
            nx.rep_cnt = '0;
        end
        // Receive count; the interrupt needs its enable bit set.
        if (ev.rx_char_done) begin
            nx.rx_cnt = step(st.rx_cnt, st.rx_num);
            set_bits[STAT_RX_REACHED] = (st.rx_cnt == st.rx_num);
        end
        // Automatic parity on the first reset-answer byte.
        if (!st.auto_parity_on) begin
            nx.par_flip = 1'b0;
        end else if (ev.first_reset_answer_byte_valid) begin
            nx.par_flip = (ev.rx_byte != st.first_byte_match_value);
        end
        nx.par_out = st.auto_parity_on ?
                     (st.fixed_parity_select ^ st.par_flip) :
                     st.fixed_parity_select;
        // Sticky status: a new event wins over a clear in one cycle.
        nx.status = ((st.status & ~w1c) | set_bits) & STATUS_USED;
        nx.irq = |(nx.status & nx.interrupt_enable_reg);
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
            st.dir_rx <= RST_DIR_RX;
            st.hready <= 1'b1;
        end else begin
            st <= nx;
        end
    end

    assign hreadyout = st.hready;
    assign hresp = 1'b0;
    assign hrdata = st.hrdata;
    assign card_clk = st.card_clk;
    assign interface_clk = st.if_clk;
    assign etu_tick = st.etu_tick;
    assign guard_busy = st.guard_busy;
    assign rx_direction = st.dir_rx;
    assign parity_select = st.par_out;
    assign repeat_limit = st.parity_repeat_max;
    assign reverse_delay = st.rev_delay;
    assign irq = st.irq;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    guard_length_a: assert property (
        guard_start && !guard_busy |=>
            st.guard_cnt == GUARD_BASE_ETU + {1'b0, $past(st.guard_time)})
        else $error("guard count not eleven plus setting");

    repeat_limit_a: assert property (
        rx_parity_err && st.rep_cnt == st.parity_repeat_max |=>
            st.status[STAT_REP_EXCEEDED] && st.rep_cnt == '0)
        else $error("repetition limit not flagged");

    rev_delay_a: assert property (
        wr_now && st.addr == OFF_REVERSE_DELAY |=>
            reverse_delay == $past(hwdata[7:0]))
        else $error("reverse delay not stored");

    if_divide_a: assert property (
        st.if_pre != st.interface_clock_divider && !wr_now |=>
            $stable(interface_clk))
        else $error("interface clock toggled early");

    card_divide_a: assert property (
        card_tick |=> card_clk != $past(card_clk))
        else $error("card clock missed a toggle");

    tx_count_a: assert property (
        tx_char_done && !st.dir_rx && st.tx_cnt == st.tx_num |=>
            st.status[STAT_TX_DONE] && st.tx_cnt == '0)
        else $error("transmit count end not flagged");

    auto_switch_a: assert property (
        tx_char_done && !st.dir_rx && st.tx_cnt == st.tx_num &&
        st.interrupt_enable_reg[IER_AUTO_SWITCH] |=> rx_direction)
        else $error("no switch to receive");

    pe_reach_a: assert property (
        rx_parity_err && st.pe_cnt == st.pe_num
        && st.interrupt_enable_reg[STAT_PE_REACHED] |=> ##1 irq)
        else $error("parity error threshold without interrupt");

    rx_reach_a: assert property (
        rx_char_done && st.rx_cnt != st.rx_num && !wr_now |=>
            st.status[STAT_RX_REACHED] == $past(st.status[STAT_RX_REACHED]))
        else $error("receive threshold flagged early");

    auto_enable_a: assert property (
        wr_now && st.addr == OFF_AUTO_PARITY |=>
            st.auto_parity_on == $past(hwdata[AUTO_ON_BIT]))
        else $error("auto parity enable not stored");

    auto_parity_a: assert property (
        st.auto_parity_on && first_reset_answer_byte_valid &&
        rx_byte != st.first_byte_match_value && !wr_now |=> ##1
            parity_select == !$past(st.fixed_parity_select))
        else $error("mismatch did not change parity");

    fixed_parity_a: assert property (
        !st.auto_parity_on |=> parity_select == $past(st.fixed_parity_select))
        else $error("parity not taken from fixed setting");

    etu_period_a: assert property (
        card_rise && st.etu_cnt == etu_len(st.tuning, st.fine) - ETU_MIN
        |=> etu_tick)
        else $error("etu tick missing");

    etu_quiet_a: assert property (
        !card_rise |=> !etu_tick)
        else $error("etu tick without card clock rise");

    status_hold_a: assert property (
        !(wr_now && st.addr == OFF_INT_STATUS) |=>
            (st.status & $past(st.status)) == $past(st.status))
        else $error("status bit fell without a clear");

    irq_level_a: assert property (
        irq == |(st.status & st.interrupt_enable_reg))
        else $error("interrupt not level of enabled status");

    // A read waits one cycle for its data; a write waits none.
    read_wait_a: assert property (
        accept && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");

    write_nowait_a: assert property (
        accept && hwrite |=> hreadyout)
        else $error("write inserted a wait state");

    read_hold_a: assert property (
        !st.rd_pend |=> $stable(hrdata))
        else $error("read data changed without a read");

    guard_hold_a: assert property (
        guard_busy && !etu_tick |=> $stable(st.guard_cnt))
        else $error("guard count moved without an etu");

    rep_clear_a: assert property (
        rx_char_done && !rx_parity_err |=> st.rep_cnt == '0)
        else $error("good character did not clear repetitions");

    tx_step_a: assert property (
        tx_char_done && !st.dir_rx && st.tx_cnt != st.tx_num && !wr_now
        |=> st.tx_cnt == $past(st.tx_cnt) + 16'h0001)
        else $error("transmit count did not advance");

    pe_step_a: assert property (
        rx_parity_err && st.pe_cnt != st.pe_num |=>
            st.pe_cnt == $past(st.pe_cnt) + 16'h0001)
        else $error("parity error count did not advance");

    rx_step_a: assert property (
        rx_char_done && st.rx_cnt != st.rx_num |=>
            st.rx_cnt == $past(st.rx_cnt) + 16'h0001)
        else $error("receive count did not advance");

endmodule

// *** sim/card_events.sv ***
// Behavioural model of the card side that reports character events.
`timescale 1ns/10ps
module card_events (
    // Clock
    input wire logic hclk,
    // Character events towards the timing block
    output logic tx_char_done,
    output logic rx_char_done,
    output logic rx_parity_err,
    output logic first_reset_answer_byte_valid,
    output logic [7:0] rx_byte,
    output logic guard_start
);
    initial begin
        tx_char_done = 1'b0;
        rx_char_done = 1'b0;
        rx_parity_err = 1'b0;
        first_reset_answer_byte_valid = 1'b0;
        rx_byte = 8'h5A;
        guard_start = 1'b0;
    end

    // One-cycle pulse: 0 sent, 1 received, 2 parity error, 3 guard start.
    task automatic pulse(input int k);
        case (k)
            0: tx_char_done <= 1'b1;
            1: rx_char_done <= 1'b1;
            2: rx_parity_err <= 1'b1;
            default: guard_start <= 1'b1;
        endcase
        @(posedge hclk);
        tx_char_done <= 1'b0;
        rx_char_done <= 1'b0;
        rx_parity_err <= 1'b0;
        guard_start <= 1'b0;
        @(posedge hclk);
    endtask

    // First answer byte; the data bus shows the inverse once released.
    task automatic atr(input logic [7:0] b);
        rx_byte <= b;
        first_reset_answer_byte_valid <= 1'b1;
        @(posedge hclk);
        first_reset_answer_byte_valid <= 1'b0;
        rx_byte <= ~b;
        @(posedge hclk);
    endtask
endmodule

// *** sim/testbench.sv ***
// Self-checking testbench of the smart-card timing block.
`timescale 1ns/10ps
module testbench
    import sc_timing_pkg::*;
;
    logic hclk, hresetn, hsel, hwrite;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hreadyout, hresp, card_clk, interface_clk, etu_tick, guard_busy;
    logic rx_direction, parity_select, irq;
    logic [3:0] repeat_limit;
    logic [7:0] reverse_delay, rx_byte;
    logic tx_char_done, rx_char_done, rx_parity_err, first_reset_answer_byte_valid;
    logic guard_start;
    int err_count, checked;
    logic [7:0] offs [9] = '{OFF_GUARD_TIME, OFF_REPEAT_LIMIT,
        OFF_REVERSE_DELAY, OFF_CLOCK_DIVIDER, OFF_TRANSMIT_COUNT,
        OFF_PE_THRESHOLD, OFF_RX_THRESHOLD, OFF_AUTO_PARITY, 8'h3C};
    logic [31:0] msk [9] = '{32'hFF, 32'hF, 32'hFF, 32'hFFFF, 32'hFFFF,
        32'hFFFF, 32'hFFFF, 32'h0, 32'h0};

    sc_timing dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .tx_char_done(tx_char_done),
        .rx_char_done(rx_char_done), .rx_parity_err(rx_parity_err),
        .first_reset_answer_byte_valid(first_reset_answer_byte_valid), .rx_byte(rx_byte),
        .guard_start(guard_start), .card_clk(card_clk),
        .interface_clk(interface_clk), .etu_tick(etu_tick),
        .guard_busy(guard_busy), .rx_direction(rx_direction),
        .parity_select(parity_select), .repeat_limit(repeat_limit),
        .reverse_delay(reverse_delay), .irq(irq));

    card_events ev_u (.hclk(hclk), .tx_char_done(tx_char_done),
        .rx_char_done(rx_char_done), .rx_parity_err(rx_parity_err),
        .first_reset_answer_byte_valid(first_reset_answer_byte_valid), .rx_byte(rx_byte),
        .guard_start(guard_start));

    // ****************************************************************
    // Checking and bus tasks
    // ****************************************************************
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] s, e);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic hang(input string nm);
        err_count++;
        $display("MISMATCH %s wait expected done seen timeout", nm);
        tally_and_finish();
    endtask

    // The master holds each phase until hready is sampled high.
    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= w;
        hsize <= 3'b010;
        htrans <= 2'b10;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 50) begin
            @(posedge hclk);
            n++;
        end
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 50) begin
            @(posedge hclk);
            n++;
        end
        r = hrdata;
        if (n >= 50) hang("bus");
        chk("hresp", {31'h0, hresp}, 32'h0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(a, 1'b1, d, r);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(a, 1'b0, 32'h0, r);
        chk($sformatf("reg %h", a), r, e);
    endtask

    // Cycles between two rising edges: 0 card, 1 interface, 2 ETU tick.
    task automatic period(input int w, output int n);
        logic pv, v;
        int c, e;
        pv = 1'b1;
        c = 0;
        e = 0;
        n = 0;
        while (e < 2 && c < 500) begin
            @(posedge hclk);
            v = (w == 0) ? card_clk : (w == 1) ? interface_clk : etu_tick;
            c++;
            if (v === 1'b1 && pv === 1'b0) begin
                e++;
                n = (e == 1) ? c : c - n;
            end
            pv = v;
        end
        if (e < 2) hang("period");
    endtask

    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        int n, i;
        logic seen;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        hwrite = 1'b0;
        htrans = 2'b00;
        hsize = 3'b010;
        hwdata = 32'h0;
        err_count = 0;
        checked = 0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (offs[k]) rdchk(offs[k], 32'h0);
        foreach (offs[k]) begin
            wr(offs[k], 32'hFFFFFFFF);
            rdchk(offs[k], msk[k]);
        end
        chk("repeat_limit", {28'h0, repeat_limit}, 32'hF);
        chk("reverse_delay", {24'h0, reverse_delay}, 32'hFF);
        foreach (offs[k]) wr(offs[k], 32'h0);
        // Receive threshold with interrupt raised, masked and cleared.
        wr(OFF_RX_THRESHOLD, 32'h2);
        wr(OFF_INT_ENABLE, 32'h4000);
        for (i = 0; i < 2; i++) ev_u.pulse(1);
        rdchk(OFF_INT_STATUS, 32'h0);
        ev_u.pulse(1);
        rdchk(OFF_INT_STATUS, 32'h4000);
        chk("irq", {31'h0, irq}, 32'h1);
        wr(OFF_INT_ENABLE, 32'h0);
        repeat (3) @(posedge hclk);
        chk("irq masked", {31'h0, irq}, 32'h0);
        wr(OFF_INT_STATUS, 32'hFFFF);
        rdchk(OFF_INT_STATUS, 32'h0);
        // Parity-error threshold.
        wr(OFF_REPEAT_LIMIT, 32'h1);
        wr(OFF_PE_THRESHOLD, 32'h1);
        wr(OFF_INT_ENABLE, 32'h4);
        ev_u.pulse(2);
        rdchk(OFF_INT_STATUS, 32'h0);
        ev_u.pulse(2);
        rdchk(OFF_INT_STATUS, 32'h44);
        chk("irq pe", {31'h0, irq}, 32'h1);
        wr(OFF_INT_ENABLE, 32'h0);
        wr(OFF_INT_STATUS, 32'hFFFF);
        // Transmit count and switch to receive, first without enable.
        wr(OFF_CONTROL, 32'h0);
        wr(OFF_TRANSMIT_COUNT, 32'h2);
        for (i = 0; i < 3; i++) ev_u.pulse(0);
        chk("dir no switch", {31'h0, rx_direction}, 32'h0);
        wr(OFF_INT_ENABLE, 32'h2000);
        for (i = 0; i < 2; i++) ev_u.pulse(0);
        chk("dir after two", {31'h0, rx_direction}, 32'h0);
        ev_u.pulse(0);
        chk("dir after three", {31'h0, rx_direction}, 32'h1);
        wr(OFF_INT_ENABLE, 32'h0);
        wr(OFF_INT_STATUS, 32'hFFFF);
        // Parity source, fixed and automatic.
        wr(OFF_CONTROL, 32'h21);
        repeat (2) @(posedge hclk);
        chk("parity fixed", {31'h0, parity_select}, 32'h1);
        wr(OFF_AUTO_PARITY, 32'h13B);
        ev_u.atr(8'h3B);
        repeat (2) @(posedge hclk);
        chk("parity match", {31'h0, parity_select}, 32'h1);
        ev_u.atr(8'h3A);
        repeat (2) @(posedge hclk);
        chk("parity change", {31'h0, parity_select}, 32'h0);
        wr(OFF_AUTO_PARITY, 32'h0);
        repeat (2) @(posedge hclk);
        chk("parity auto off", {31'h0, parity_select}, 32'h1);
        // Clock dividers and ETU length.
        wr(OFF_CLOCK_DIVIDER, 32'h0201);
        period(0, n);
        chk("card period", n, 32'd4);
        period(1, n);
        chk("interface period", n, 32'd6);
        wr(OFF_CLOCK_DIVIDER, 32'h0);
        wr(OFF_BAUD, 32'h12);
        period(2, n);
        chk("etu period", n, 32'd24);
        // Guard time of eleven plus two ETU.
        wr(OFF_BAUD, 32'h1);
        wr(OFF_GUARD_TIME, 32'h2);
        n = 0;
        i = 0;
        seen = 1'b0;
        fork
            ev_u.pulse(3);
            while (i < 300 && !(seen && guard_busy === 1'b0)) begin
                @(posedge hclk);
                i++;
                if (guard_busy === 1'b1) seen = 1'b1;
                if (guard_busy === 1'b1 && etu_tick === 1'b1) n++;
            end
        join
        if (i >= 300) hang("guard");
        chk("guard etu", n, 32'd13);
        tally_and_finish();
    end
endmodule
